// File: include/apd_pkg.sv
/*
  Shared constants and carrier types for the audio playback datapath:
  register offsets, reset values, stage timing and bus bundles.
  Assumes a single 250 MHz clock derived from the crystal input clock.
*/
package apd_pkg;

  // clock and rates
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned DAC_DIV         = 2;     // dac runs at half the crystal clock
  localparam int unsigned SRC_RATIO       = 128;   // dac rate over highest sample rate
  localparam int unsigned ZC_TIMEOUT_NS   = 4000;  // zero-crossing wait before forcing volume
  localparam int unsigned ZC_TIMEOUT_CYC  = ZC_TIMEOUT_NS / CLK_PERIOD_NS;

  // widths and sizes
  localparam int unsigned SMP_W    = 16;
  localparam int unsigned DAC_W    = 18;
  localparam int unsigned FIFO_AW  = 11;
  localparam int unsigned FIFO_DEPTH = 2048;
  localparam int unsigned ADDR_W   = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_TONE     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_APP_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] REG_VOL      = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_RATE_DIV = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h14;

  // field positions
  localparam int unsigned CTRL_REC_BIT   = 0;
  localparam int unsigned CTRL_SPAT_BIT  = 1;
  localparam int unsigned ST_MUTE_BIT    = 16;
  localparam int unsigned ST_VPEND_BIT   = 17;
  localparam int unsigned ST_HOOK_BIT    = 18;

  // reset values
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam logic [3:0]  TONE_RST     = 4'h0;
  localparam logic [15:0] APP_ADDR_RST = 16'h0000;
  localparam logic [15:0] VOL_RST      = 16'h0000;
  localparam logic [15:0] RATE_DIV_RST = 16'h1458;  // 250 MHz / 48 kHz

  // tone and upsampler shaping
  localparam int unsigned TONE_LP_SH = 4;
  localparam int unsigned SRC_SH     = 5;
  localparam int unsigned SRC_FRAC   = 4;

  // percussion key span
  localparam logic [6:0] PERC_KEY_LO = 7'h1b;  // 27
  localparam logic [6:0] PERC_KEY_HI = 7'h57;  // 87

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic signed [SMP_W-1:0] l;
    logic signed [SMP_W-1:0] r;
  } apd_stereo_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } apd_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } apd_axi_rsp_t;

endpackage

// File: src/apd_fifo_mem.sv
/*
  Simple dual-port sample memory for the audio fifo, one stereo word per entry.
  Assumes the owner keeps pointers; read data is registered, one cycle late.
*/
`timescale 1ns/1ps
module apd_fifo_mem
  import apd_pkg::*;
(
  input  wire logic                 clk,    // clock
  input  wire logic                 wr_en,  // write strobe
  input  wire logic [FIFO_AW-1:0]   wr_addr,// write index
  input  wire apd_stereo_t          wr_data,// write word
  input  wire logic                 rd_en,  // read strobe
  input  wire logic [FIFO_AW-1:0]   rd_addr,// read index
  output apd_stereo_t               rd_data // registered read word
);
  apd_stereo_t mem [FIFO_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// File: src/apd_top.sv
/*
  Audio playback datapath: input gating, application hook, tone stage,
  spatial stage, 2048-entry audio fifo, interrupt drain, upsampler,
  zero-cross volume, dac feed, auto mute and percussion key map.
  Assumes an AXI4-Lite master on the register port and a sample source
  that holds SMP_VALID and SMP_DATA until SMP_READY.
*/
`timescale 1ns/1ps
module apd_top
  import apd_pkg::*;
#(
  parameter int unsigned ZC_TIMEOUT = ZC_TIMEOUT_CYC
)(
  input  wire logic               CLK,        // 250 MHz clock
  input  wire logic               RST,        // sync reset, active high
  input  wire apd_axi_req_t       AXI_REQ,    // axi4-lite master signals
  output apd_axi_rsp_t            AXI_RSP,    // axi4-lite slave signals
  input  wire logic               SMP_VALID,  // decoded sample valid
  input  wire apd_stereo_t        SMP_DATA,   // decoded stereo sample
  output logic                    SMP_READY,  // sample taken when high
  input  wire logic               DATA_BAD,   // decoder reports invalid input
  output logic                    HOOK_REQ,   // hook call pending
  output logic [15:0]             HOOK_ADDR,  // app_start_address
  output apd_stereo_t             HOOK_DATA,  // sample handed to hook
  input  wire logic               HOOK_ACK,   // hook finished
  input  wire apd_stereo_t        HOOK_RDATA, // sample returned by hook
  output logic signed [DAC_W-1:0] DAC_L,      // left dac word
  output logic signed [DAC_W-1:0] DAC_R,      // right dac word
  output logic                    DAC_STB,    // dac update pulse
  output logic                    MUTE,       // outputs muted
  input  wire logic [6:0]         PERC_KEY,   // percussion key number
  output logic                    PERC_HIT,   // key has an instrument
  output logic [5:0]              PERC_INST,  // instrument index
  output logic [2:0]              PERC_EXCL   // exclusive_class, 0 none
);
  typedef enum logic [2:0] {S_IDLE, S_HOOK, S_TONE, S_SPAT, S_PUSH} apd_state_t;

  apd_state_t state_q, state_d;
  apd_stereo_t smp_q;
  logic [1:0]  ctrl_q;
  logic [3:0]  tone_q;
  logic [15:0] app_addr_q, vol_q, rate_div_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        aw_held_q, w_held_q, wr_fire, wr_ok;
  logic signed [SMP_W-1:0] lp_l_q, lp_r_q;
  logic [FIFO_AW:0] wr_ptr_q, rd_ptr_q, fill;
  logic        fifo_full, fifo_empty, fifo_wr, fifo_rd, rd_pend_q;
  apd_stereo_t fifo_q;
  logic [15:0] rate_cnt_q;
  logic        drain_tick;
  logic signed [SMP_W-1:0] cur_l_q, cur_r_q;
  logic        dac_ph_q;
  logic signed [DAC_W+SRC_FRAC-1:0] acc_l_q, acc_r_q;
  logic signed [DAC_W-1:0] up_l, up_r, prev_l_q, prev_r_q;
  logic [7:0]  att_l_q, att_r_q;
  logic        pend_l_q, pend_r_q;
  logic [31:0] tmo_q;
  logic        mute_q;

  function automatic logic signed [SMP_W-1:0] sat16(input logic signed [19:0] v);
    if (v > 20'sd32767) return 16'sh7fff;
    if (v < -20'sd32768) return 16'sh8000;
    return v[SMP_W-1:0];
  endfunction

  function automatic logic signed [SMP_W-1:0] tone(input logic signed [SMP_W-1:0] x,
                                                   input logic signed [SMP_W-1:0] lp,
                                                   input logic [3:0] t);
    logic signed [19:0] hp;
    logic signed [19:0] y;
    hp = 20'(x) - 20'(lp);
    y  = 20'(x) + ((20'(lp) * $signed({1'b0, t[1:0]})) >>> 2)
                + ((hp * $signed({1'b0, t[3:2]})) >>> 2);
    return sat16(y);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // axi4-lite write path: address and data taken in either order
  assign wr_fire = aw_held_q && w_held_q && !AXI_RSP.bvalid;
  assign wr_ok   = awaddr_q inside {REG_CTRL, REG_TONE, REG_APP_ADDR, REG_VOL, REG_RATE_DIV};

  always_ff @(posedge CLK) begin
    if (RST) begin
      aw_held_q       <= 1'b0;
      w_held_q        <= 1'b0;
      awaddr_q        <= '0;
      wdata_q         <= '0;
      wstrb_q         <= '0;
      AXI_RSP.awready <= 1'b1;
      AXI_RSP.wready  <= 1'b1;
      AXI_RSP.bvalid  <= 1'b0;
      AXI_RSP.bresp   <= RESP_OKAY;
    end else begin
      if (AXI_REQ.awvalid && AXI_RSP.awready) begin
        awaddr_q        <= {AXI_REQ.awaddr[ADDR_W-1:2], 2'b00};
        aw_held_q       <= 1'b1;
        AXI_RSP.awready <= 1'b0;
      end
      if (AXI_REQ.wvalid && AXI_RSP.wready) begin
        wdata_q        <= AXI_REQ.wdata;
        wstrb_q        <= AXI_REQ.wstrb;
        w_held_q       <= 1'b1;
        AXI_RSP.wready <= 1'b0;
      end
      if (wr_fire) begin
        AXI_RSP.bvalid <= 1'b1;
        AXI_RSP.bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (AXI_RSP.bvalid && AXI_REQ.bready) begin
        AXI_RSP.bvalid  <= 1'b0;
        aw_held_q       <= 1'b0;
        w_held_q        <= 1'b0;
        AXI_RSP.awready <= 1'b1;
        AXI_RSP.wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q     <= CTRL_RST;
      tone_q     <= TONE_RST;
      app_addr_q <= APP_ADDR_RST;
      vol_q      <= VOL_RST;
      rate_div_q <= RATE_DIV_RST;
    end else if (wr_fire) begin
      case (awaddr_q)
        REG_CTRL:     ctrl_q     <= 2'(merge(32'(ctrl_q), wdata_q, wstrb_q));
        REG_TONE:     tone_q     <= 4'(merge(32'(tone_q), wdata_q, wstrb_q));
        REG_APP_ADDR: app_addr_q <= 16'(merge(32'(app_addr_q), wdata_q, wstrb_q));
        REG_VOL:      vol_q      <= 16'(merge(32'(vol_q), wdata_q, wstrb_q));
        REG_RATE_DIV: rate_div_q <= 16'(merge(32'(rate_div_q), wdata_q, wstrb_q));
        default:      ;
      endcase
    end
  end

  // axi4-lite read path, answer one cycle after the address
  always_ff @(posedge CLK) begin
    if (RST) begin
      AXI_RSP.arready <= 1'b1;
      AXI_RSP.rvalid  <= 1'b0;
      AXI_RSP.rdata   <= '0;
      AXI_RSP.rresp   <= RESP_OKAY;
    end else if (AXI_REQ.arvalid && AXI_RSP.arready) begin
      AXI_RSP.arready <= 1'b0;
      AXI_RSP.rvalid  <= 1'b1;
      AXI_RSP.rresp   <= RESP_OKAY;
      case ({AXI_REQ.araddr[ADDR_W-1:2], 2'b00})
        REG_CTRL:     AXI_RSP.rdata <= 32'(ctrl_q);
        REG_TONE:     AXI_RSP.rdata <= 32'(tone_q);
        REG_APP_ADDR: AXI_RSP.rdata <= 32'(app_addr_q);
        REG_VOL:      AXI_RSP.rdata <= 32'(vol_q);
        REG_RATE_DIV: AXI_RSP.rdata <= 32'(rate_div_q);
        REG_STATUS:   AXI_RSP.rdata <= {13'h0, HOOK_REQ, pend_l_q | pend_r_q, mute_q,
                                        4'h0, fill};
        default: begin
          AXI_RSP.rdata <= '0;
          AXI_RSP.rresp <= RESP_SLVERR;
        end
      endcase
    end else if (AXI_RSP.rvalid && AXI_REQ.rready) begin
      AXI_RSP.rvalid  <= 1'b0;
      AXI_RSP.arready <= 1'b1;
    end
  end

  // processing sequencer, one sample in flight
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (SMP_VALID && SMP_READY) begin
          state_d = (app_addr_q != 16'h0) ? S_HOOK : S_TONE;
        end
      end
      S_HOOK:  state_d = HOOK_ACK ? S_TONE : S_HOOK;
      S_TONE:  state_d = S_SPAT;
      S_SPAT:  state_d = S_PUSH;
      S_PUSH:  state_d = fifo_full ? S_PUSH : S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q   <= S_IDLE;
      SMP_READY <= 1'b0;
      HOOK_REQ  <= 1'b0;
      HOOK_ADDR <= '0;
      HOOK_DATA <= '0;
    end else begin
      state_q   <= state_d;
      SMP_READY <= (state_d == S_IDLE) && !state_q[0] && !ctrl_q[CTRL_REC_BIT]
                   && !(SMP_VALID && SMP_READY);
      HOOK_REQ  <= (state_d == S_HOOK) && !(state_q == S_HOOK && HOOK_ACK);
      if (state_q == S_IDLE && state_d == S_HOOK) begin
        HOOK_ADDR <= app_addr_q;
        HOOK_DATA <= SMP_DATA;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      smp_q  <= '0;
      lp_l_q <= '0;
      lp_r_q <= '0;
    end else begin
      case (state_q)
        S_IDLE: if (SMP_VALID && SMP_READY) smp_q <= SMP_DATA;
        S_HOOK: if (HOOK_ACK) smp_q <= HOOK_RDATA;
        S_TONE: begin
          smp_q.l <= tone(smp_q.l, lp_l_q, tone_q);
          smp_q.r <= tone(smp_q.r, lp_r_q, tone_q);
          lp_l_q  <= sat16(20'(lp_l_q) + ((20'(smp_q.l) - 20'(lp_l_q)) >>> TONE_LP_SH));
          lp_r_q  <= sat16(20'(lp_r_q) + ((20'(smp_q.r) - 20'(lp_r_q)) >>> TONE_LP_SH));
        end
        S_SPAT: begin
          if (ctrl_q[CTRL_SPAT_BIT]) begin
            smp_q.l <= sat16((20'(smp_q.l) * 20'sd3 + 20'(smp_q.r)) >>> 2);
            smp_q.r <= sat16((20'(smp_q.r) * 20'sd3 + 20'(smp_q.l)) >>> 2);
          end
        end
        default: ;
      endcase
    end
  end

  assign fill       = wr_ptr_q - rd_ptr_q;
  assign fifo_full  = fill == (FIFO_AW+1)'(FIFO_DEPTH);
  assign fifo_empty = fill == '0;
  assign fifo_wr    = (state_q == S_PUSH) && !fifo_full;
  assign fifo_rd    = drain_tick && !fifo_empty;

  apd_fifo_mem u_mem (
    .clk     (CLK),
    .wr_en   (fifo_wr),
    .wr_addr (wr_ptr_q[FIFO_AW-1:0]),
    .wr_data (smp_q),
    .rd_en   (fifo_rd),
    .rd_addr (rd_ptr_q[FIFO_AW-1:0]),
    .rd_data (fifo_q)
  );

  // periodic drain acts as audio interrupt
  assign drain_tick = rate_cnt_q >= rate_div_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      rate_cnt_q <= 16'h1;
      rd_pend_q  <= 1'b0;
      cur_l_q    <= '0;
      cur_r_q    <= '0;
    end else begin
      if (fifo_wr) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (fifo_rd) rd_ptr_q <= rd_ptr_q + 1'b1;
      rate_cnt_q <= drain_tick ? 16'h1 : rate_cnt_q + 16'h1;
      rd_pend_q  <= fifo_rd;
      if (rd_pend_q) begin
        cur_l_q <= fifo_q.l;
        cur_r_q <= fifo_q.r;
      end
    end
  end

  // mute on bad data or underrun
  always_ff @(posedge CLK) begin
    if (RST) begin
      mute_q <= 1'b1;
    end else if (DATA_BAD || (drain_tick && fifo_empty)) begin
      mute_q <= 1'b1;
    end else if (fifo_rd) begin
      mute_q <= 1'b0;
    end
  end

  // 18-bit smoothing upsampler at half clock
  assign up_l = acc_l_q[DAC_W+SRC_FRAC-1:SRC_FRAC];
  assign up_r = acc_r_q[DAC_W+SRC_FRAC-1:SRC_FRAC];

  always_ff @(posedge CLK) begin
    if (RST) begin
      dac_ph_q <= 1'b0;
      acc_l_q  <= '0;
      acc_r_q  <= '0;
      prev_l_q <= '0;
      prev_r_q <= '0;
    end else begin
      dac_ph_q <= ~dac_ph_q;
      if (dac_ph_q) begin
        // shift before subtracting, the raw difference overflows 22 bits
        acc_l_q  <= acc_l_q + ($signed({cur_l_q, 6'h0}) >>> SRC_SH) - (acc_l_q >>> SRC_SH);
        acc_r_q  <= acc_r_q + ($signed({cur_r_q, 6'h0}) >>> SRC_SH) - (acc_r_q >>> SRC_SH);
        prev_l_q <= up_l;
        prev_r_q <= up_r;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      att_l_q  <= VOL_RST[7:0];
      att_r_q  <= VOL_RST[15:8];
      pend_l_q <= 1'b0;
      pend_r_q <= 1'b0;
      tmo_q    <= '0;
    end else if (wr_fire && awaddr_q == REG_VOL) begin
      pend_l_q <= 1'b1;
      pend_r_q <= 1'b1;
      tmo_q    <= '0;
    end else begin
      tmo_q <= (pend_l_q || pend_r_q) ? tmo_q + 32'h1 : '0;
      if (tmo_q >= 32'(ZC_TIMEOUT) - 32'h1) begin
        att_l_q  <= vol_q[7:0];
        att_r_q  <= vol_q[15:8];
        pend_l_q <= 1'b0;
        pend_r_q <= 1'b0;
      end else if (dac_ph_q) begin
        if (pend_l_q && (up_l == '0 || up_l[DAC_W-1] != prev_l_q[DAC_W-1])) begin
          att_l_q  <= vol_q[7:0];
          pend_l_q <= 1'b0;
        end
        if (pend_r_q && (up_r == '0 || up_r[DAC_W-1] != prev_r_q[DAC_W-1])) begin
          att_r_q  <= vol_q[15:8];
          pend_r_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      DAC_L   <= '0;
      DAC_R   <= '0;
      DAC_STB <= 1'b0;
      MUTE    <= 1'b1;
    end else begin
      DAC_STB <= dac_ph_q;
      MUTE    <= mute_q;
      if (dac_ph_q) begin
        DAC_L <= mute_q ? '0 : DAC_W'((28'(up_l) * $signed({2'b00, 9'h100 - 9'(att_l_q)}))
                                      >>> 8);
        DAC_R <= mute_q ? '0 : DAC_W'((28'(up_r) * $signed({2'b00, 9'h100 - 9'(att_r_q)}))
                                      >>> 8);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PERC_HIT  <= 1'b0;
      PERC_INST <= '0;
      PERC_EXCL <= '0;
    end else begin
      PERC_HIT  <= PERC_KEY >= PERC_KEY_LO && PERC_KEY <= PERC_KEY_HI;
      PERC_INST <= (PERC_KEY >= PERC_KEY_LO && PERC_KEY <= PERC_KEY_HI)
                   ? 6'(PERC_KEY - PERC_KEY_LO) : 6'h0;
      case (PERC_KEY)
        7'h2a, 7'h2c, 7'h2e: PERC_EXCL <= 3'h1;
        7'h47, 7'h48:        PERC_EXCL <= 3'h2;
        7'h49, 7'h4a:        PERC_EXCL <= 3'h3;
        7'h4e, 7'h4f:        PERC_EXCL <= 3'h4;
        7'h50, 7'h51:        PERC_EXCL <= 3'h5;
        7'h56, 7'h57:        PERC_EXCL <= 3'h6;
        7'h1d, 7'h1e:        PERC_EXCL <= 3'h7;
        default:             PERC_EXCL <= 3'h0;
      endcase
    end
  end
endmodule

// File: verification/apd_top_asserts.sv
/* Port checker for the playback datapath.
   Assumes bind into apd_top, one clock CLK, synchronous reset RST. */
`timescale 1ns/1ps
module apd_top_asserts
  import apd_pkg::*;
#(
  parameter int unsigned ZC_TIMEOUT = 50
)(
  input wire logic                    CLK,       // clock
  input wire logic                    RST,       // reset
  input wire logic                    SMP_VALID, // sample offered
  input wire logic                    SMP_READY, // sample taken
  input wire logic                    DATA_BAD,  // invalid input
  input wire logic                    HOOK_REQ,  // hook pending
  input wire logic [15:0]             HOOK_ADDR, // hook address
  input wire logic signed [DAC_W-1:0] DAC_L,     // left word
  input wire logic signed [DAC_W-1:0] DAC_R,     // right word
  input wire logic                    DAC_STB,   // dac strobe
  input wire logic                    MUTE,      // muted
  input wire logic [6:0]              PERC_KEY,  // key number
  input wire logic                    PERC_HIT,  // key mapped
  input wire logic [5:0]              PERC_INST, // instrument
  input wire logic [2:0]              PERC_EXCL  // class
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  property p_stb_alt;
    DAC_STB |=> !DAC_STB ##1 DAC_STB;
  endproperty
  a_stb_alt: assert property (p_stb_alt) else $error("dac strobe not alternating");
  property p_dac_hold;
    !DAC_STB && !$past(RST) |-> $stable(DAC_L) && $stable(DAC_R);
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("dac moved without strobe");
  // mute port lags, so allow one strobe to land
  property p_mute_zero;
    MUTE [*3] |-> DAC_L == 0 && DAC_R == 0;
  endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("muted output not zero");
  property p_mute_bad;
    DATA_BAD |-> ##[1:3] MUTE;
  endproperty
  a_mute_bad: assert property (p_mute_bad) else $error("bad input not muted");
  property p_take_drop;
    SMP_VALID && SMP_READY |=> !SMP_READY;
  endproperty
  a_take_drop: assert property (p_take_drop) else $error("ready held after take");
  property p_hook_start;
    $rose(HOOK_REQ) |-> $past(SMP_VALID && SMP_READY) && HOOK_ADDR != 16'h0000;
  endproperty
  a_hook_start: assert property (p_hook_start) else $error("hook call without cause");
  property p_hook_block;
    HOOK_REQ |-> !SMP_READY;
  endproperty
  a_hook_block: assert property (p_hook_block) else $error("ready during hook");
  property p_perc_hit;
    1'b1 |=> PERC_HIT == ($past(PERC_KEY) >= PERC_KEY_LO && $past(PERC_KEY) <= PERC_KEY_HI);
  endproperty
  a_perc_hit: assert property (p_perc_hit) else $error("key hit wrong");
  property p_perc_inst;
    PERC_HIT |-> PERC_INST == 6'($past(PERC_KEY) - PERC_KEY_LO);
  endproperty
  a_perc_inst: assert property (p_perc_inst) else $error("instrument index wrong");
  property p_perc_none;
    !PERC_HIT |-> PERC_INST == 6'h00 && PERC_EXCL == 3'h0;
  endproperty
  a_perc_none: assert property (p_perc_none) else $error("unmapped key not empty");
endmodule
bind apd_top apd_top_asserts #(.ZC_TIMEOUT(ZC_TIMEOUT)) u_asserts (
  .CLK(CLK), .RST(RST), .SMP_VALID(SMP_VALID), .SMP_READY(SMP_READY),
  .DATA_BAD(DATA_BAD), .HOOK_REQ(HOOK_REQ), .HOOK_ADDR(HOOK_ADDR),
  .DAC_L(DAC_L), .DAC_R(DAC_R), .DAC_STB(DAC_STB), .MUTE(MUTE), .PERC_KEY(PERC_KEY),
  .PERC_HIT(PERC_HIT), .PERC_INST(PERC_INST), .PERC_EXCL(PERC_EXCL)
);

// File: verification/apd_host_model.sv
/* Host side: sample source and hook responder.
   Assumes the bench fills tx_q and reads hook_q and addr_q. */
`timescale 1ns/1ps
module apd_host_model
  import apd_pkg::*;
(
  input  wire logic        clk,        // clock
  input  wire logic        rst,        // reset
  input  wire logic        smp_ready,  // sample taken
  output logic             smp_valid,  // sample offered
  output apd_stereo_t      smp_data,   // sample word
  input  wire logic        hook_req,   // hook call
  input  wire apd_stereo_t hook_data,  // sample to hook
  input  wire logic [15:0] hook_addr,  // hook address
  output logic             hook_ack,   // hook done
  output apd_stereo_t      hook_rdata  // returned sample
);
  apd_stereo_t tx_q[$];
  apd_stereo_t hook_q[$];
  logic [15:0] addr_q[$];
  int          hook_dly = 2;
  int          wait_n = 0;
  initial begin
    smp_valid = 1'b0;
    smp_data = '0;
    hook_ack = 1'b0;
    hook_rdata = '0;
  end
  // idle data toggles so a stale word is never mistaken for a sample
  always @(posedge clk) begin
    if (smp_valid && smp_ready)
      void'(tx_q.pop_front());
    if (rst || tx_q.size() == 0) begin
      smp_valid <= 1'b0;
      smp_data <= ~smp_data;
    end else begin
      smp_valid <= 1'b1;
      smp_data <= tx_q[0];
    end
  end
  always @(posedge clk) begin
    hook_ack <= 1'b0;
    hook_rdata <= ~hook_rdata;
    if (rst || !hook_req || hook_ack)
      wait_n <= 0;
    else if (wait_n == hook_dly) begin
      hook_ack <= 1'b1;
      hook_rdata <= ~hook_data;
      hook_q.push_back(hook_data);
      addr_q.push_back(hook_addr);
    end else
      wait_n <= wait_n + 1;
  end
endmodule

// File: verification/tb_audio_playback_datapath.sv
/* Self-checking bench for apd_top with a register model.
   Assumes apd_host_model on the sample and hook ports. */
`timescale 1ns/1ps
module tb_audio_playback_datapath;
  import apd_pkg::*;
  localparam int ZC = 50;
  logic CLK = 1'b0, RST = 1'b1, DATA_BAD = 1'b0;
  logic SMP_VALID, SMP_READY, HOOK_REQ, HOOK_ACK, DAC_STB, MUTE, PERC_HIT;
  apd_axi_req_t AXI_REQ = '0;
  apd_axi_rsp_t AXI_RSP;
  apd_stereo_t SMP_DATA, HOOK_DATA, HOOK_RDATA, s;
  apd_stereo_t sent_q[$];
  logic [15:0] HOOK_ADDR, a;
  logic signed [DAC_W-1:0] DAC_L, DAC_R;
  logic [6:0] PERC_KEY = '0;
  logic [5:0] PERC_INST;
  logic [2:0] PERC_EXCL;
  logic [31:0] regs[6], rd;
  logic [1:0] rs;
  int n_fail = 0, checks = 0, n, hit;
  always #2 CLK = ~CLK;
  apd_top #(.ZC_TIMEOUT(ZC)) dut (.CLK(CLK), .RST(RST), .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP),
    .SMP_VALID(SMP_VALID), .SMP_DATA(SMP_DATA), .SMP_READY(SMP_READY), .DATA_BAD(DATA_BAD),
    .HOOK_REQ(HOOK_REQ), .HOOK_ADDR(HOOK_ADDR), .HOOK_DATA(HOOK_DATA), .HOOK_ACK(HOOK_ACK),
    .HOOK_RDATA(HOOK_RDATA), .DAC_L(DAC_L), .DAC_R(DAC_R), .DAC_STB(DAC_STB), .MUTE(MUTE),
    .PERC_KEY(PERC_KEY), .PERC_HIT(PERC_HIT), .PERC_INST(PERC_INST), .PERC_EXCL(PERC_EXCL));
  apd_host_model u_host (.clk(CLK), .rst(RST), .smp_ready(SMP_READY), .smp_valid(SMP_VALID),
    .smp_data(SMP_DATA), .hook_req(HOOK_REQ), .hook_data(HOOK_DATA), .hook_addr(HOOK_ADDR),
    .hook_ack(HOOK_ACK), .hook_rdata(HOOK_RDATA));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  function automatic int excl(input int k);
    case (k)
      42, 44, 46: return 1;
      71, 72: return 2;
      73, 74: return 3;
      78, 79: return 4;
      80, 81: return 5;
      86, 87: return 6;
      29, 30: return 7;
      default: return 0;
    endcase
  endfunction
  task automatic do_reset();
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    regs = '{0, 0, 0, 0, {16'h0, RATE_DIV_RST}, 0};
  endtask
  task automatic axi_wr(input int i, input logic [31:0] d);
    @(posedge CLK);
    AXI_REQ.awvalid <= 1'b1;
    AXI_REQ.awaddr <= 8'(i * 4);
    AXI_REQ.wvalid <= 1'b1;
    AXI_REQ.wdata <= d;
    AXI_REQ.wstrb <= 4'hf;
    AXI_REQ.bready <= 1'b1;
    for (n = 0; n < 100 && !AXI_RSP.bvalid; n++) begin
      @(posedge CLK);
      if (AXI_RSP.awready) AXI_REQ.awvalid <= 1'b0;
      if (AXI_RSP.wready) AXI_REQ.wvalid <= 1'b0;
    end
    n_fail += int'(n == 100);
    AXI_REQ.bready <= 1'b0;
    chk(32'(AXI_RSP.bresp), 32'(i < 5 ? RESP_OKAY : RESP_SLVERR), "write resp");
    if (i < 5) regs[i] = d & (i == 0 ? 32'h3 : i == 1 ? 32'hf : 32'hffff);
  endtask
  task automatic axi_rd(input int i);
    @(posedge CLK);
    AXI_REQ.arvalid <= 1'b1;
    AXI_REQ.araddr <= 8'(i * 4);
    AXI_REQ.rready <= 1'b1;
    for (n = 0; n < 100 && !AXI_RSP.rvalid; n++) begin
      @(posedge CLK);
      if (AXI_RSP.arready) AXI_REQ.arvalid <= 1'b0;
    end
    n_fail += int'(n == 100);
    rd = AXI_RSP.rdata;
    rs = AXI_RSP.rresp;
    AXI_REQ.rready <= 1'b0;
    if (i != 5) chk(rd, i < 5 ? regs[i] : 32'h0, "read data");
    if (i != 5) chk(32'(rs), 32'(i < 5 ? RESP_OKAY : RESP_SLVERR), "read resp");
  endtask
  task automatic send(input int k);
    repeat (k) begin
      s = $urandom;
      u_host.tx_q.push_back(s);
      sent_q.push_back(s);
    end
  endtask
  // no take for 100 cycles: stream settled or stalled
  task automatic settle();
    for (int c = 0; c < 100; c++) begin
      @(posedge CLK);
      if (SMP_VALID && SMP_READY) c = 0;
    end
  endtask
  initial begin
    #240000;
    n_fail++;
    stop_test();
  end
  initial begin
    void'($urandom(86));
    do_reset();
    for (int i = 0; i < 7; i++) axi_rd(i);
    for (int i = 1; i < 7; i++) axi_wr(i, $urandom);
    for (int i = 0; i < 5; i++) axi_rd(i);
    $display("done registers");
    for (int k = 0; k < 128; k++) begin
      PERC_KEY <= 7'(k);
      repeat (2) @(posedge CLK);
      hit = int'(k >= 27 && k <= 87);
      chk(32'(PERC_HIT), hit, "perc hit");
      chk(32'(PERC_INST), hit ? k - 27 : 0, "perc inst");
      chk(32'(PERC_EXCL), excl(k), "perc class");
    end
    $display("done percussion");
    axi_wr(2, 0);
    axi_wr(0, 32'h1);
    send(1);
    repeat (20) @(posedge CLK);
    chk(32'(u_host.tx_q.size()), 1, "record holds stream");
    axi_wr(0, 32'h0);
    settle();
    chk(32'(u_host.tx_q.size()), 0, "stream resumes");
    $display("done record mode");
    a = 16'($urandom_range(1, 65535));
    axi_wr(2, a);
    sent_q.delete();
    send(4);
    settle();
    chk(32'(u_host.hook_q.size()), 4, "hook calls");
    foreach (u_host.hook_q[j]) begin
      chk(u_host.hook_q[j], sent_q[j], "hook data");
      chk(32'(u_host.addr_q[j]), 32'(a), "hook addr");
    end
    axi_wr(2, 0);
    send(2);
    settle();
    chk(32'(u_host.hook_q.size()), 4, "no hook at zero");
    $display("done hook");
    do_reset();
    axi_wr(4, 32'hffff);
    axi_wr(1, $urandom);
    axi_wr(0, 32'h2);
    send(2052);
    settle();
    axi_rd(5);
    chk(32'(rd[11:0]), 2048, "fifo full");
    chk(32'(SMP_READY), 0, "full stalls");
    axi_wr(4, 8);
    repeat (2100 * 8) @(posedge CLK);
    axi_rd(5);
    chk(32'(rd[11:0]), 0, "fifo drained");
    chk(32'(rd[16]), 1, "underrun mute bit");
    chk(32'(MUTE), 1, "underrun mute");
    send(40);
    repeat (150) @(posedge CLK);
    chk(32'(MUTE), 0, "mute released");
    DATA_BAD <= 1'b1;
    repeat (5) @(posedge CLK);
    chk(32'(MUTE), 1, "bad input mute");
    DATA_BAD <= 1'b0;
    settle();
    $display("done fifo");
    send(40);
    axi_wr(3, $urandom);
    for (int t = 0; t < 30; t++) begin
      axi_rd(5);
      if (!rd[17]) break;
    end
    chk(32'(rd[17]), 0, "volume applied in time");
    axi_rd(3);
    $display("done volume");
    stop_test();
  end
endmodule
